// >>> src/tcc_map.svh
// Register offsets, field positions and reset values of the timer core
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// Register bus widths
`define TCC_ADDR_W          8
`define TCC_DATA_W          32

// Register byte offsets
`define TCC_OFS_MODE        8'h00
`define TCC_OFS_XMODE       8'h04
`define TCC_OFS_EVENT       8'h08
`define TCC_OFS_COMPARE     8'h0C
`define TCC_OFS_CAPTURE     8'h10
`define TCC_OFS_COUNT       8'h14
`define TCC_OFS_IRQ_MASK    8'h18

// Mode control fields
`define TCC_MODE_W          16
`define TCC_MODE_EN_BIT     0
`define TCC_MODE_CLK_LSB    1
`define TCC_MODE_CLK_MSB    2
`define TCC_MODE_FRR_BIT    3
`define TCC_MODE_COMPARE_REQUEST_ENABLE_BIT   4
`define TCC_MODE_CE_LSB     6
`define TCC_MODE_CE_MSB     7
`define TCC_MODE_PS_LSB     8
`define TCC_MODE_PS_MSB     15
`define TCC_MODE_MASK       16'hFFDF

// Extended mode fields
`define TCC_XMODE_W         8
`define TCC_XMODE_M16_BIT   0
`define TCC_XMODE_DMA_BIT   7
`define TCC_XMODE_MASK      8'h81

// Event flag fields
`define TCC_EVT_W           2
`define TCC_EVT_CAP_BIT     0
`define TCC_EVT_REF_BIT     1

// Reset values
`define TCC_RST_MODE        16'h0000
`define TCC_RST_XMODE       8'h00
`define TCC_RST_EVT         2'h0
`define TCC_RST_WORD        32'h0000_0000

// Counter steps for normal and 16-bit mirror mode
`define TCC_STEP_ONE        32'h0000_0001
`define TCC_STEP_M16        32'h0001_0001

// Fixed system clock divider
`define TCC_SYS_DIV         16

`endif

// >>> src/tcc_pkg.sv
// Types shared by the timer core modules
package tcc_pkg;

   // Counter clock source select
   typedef enum logic [1:0]
   {
      tcc_clk_stop  = 2'b00,
      tcc_clk_sys1  = 2'b01,
      tcc_clk_sys16 = 2'b10,
      tcc_clk_pin   = 2'b11
   } tcc_clk_sel_type;

   // Capture edge select
   typedef enum logic [1:0]
   {
      tcc_cap_off  = 2'b00,
      tcc_cap_rise = 2'b01,
      tcc_cap_fall = 2'b10,
      tcc_cap_any  = 2'b11
   } tcc_cap_edge_type;

endpackage

// >>> src/tcc_pin_edge.sv
// Input pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none

module tcc_pin_edge
(
   input  wire logic i_clk_sys,
   input  wire logic i_rstn,
   input  wire logic i_ce,
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);

   logic meta_ff;  // First stage, read only by the second
   logic sync_ff;  // Second stage, safe to use
   logic last_ff;  // Previous synchronised level

   // Two-stage synchroniser and edge history
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         meta_ff <= i_pin;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   // Edge pulses last one cycle
   assign o_level = sync_ff;
   assign o_rise  = sync_ff & ~last_ff;
   assign o_fall  = ~sync_ff & last_ff;

endmodule

`default_nettype wire

// >>> src/tcc_prescaler.sv
// Clock source select, fixed divider and programmable prescaler
`timescale 1ns/1ps
`default_nettype none
`include "tcc_map.svh"

module tcc_prescaler
#(
   parameter int PS_W = 8,
   parameter int DIV  = `TCC_SYS_DIV
)
(
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_rstn,
   input  wire logic                     i_ce,
   input  wire logic                     i_run,
   input  wire tcc_pkg::tcc_clk_sel_type i_sel,
   input  wire logic                     i_pin_rise,
   input  wire logic [PS_W-1:0]          i_ps,
   output logic                          o_inc
);

   localparam int DIV_W = $clog2(DIV);

   logic [DIV_W-1:0] div_ff;   // Fixed divider count
   logic [PS_W-1:0]  ps_ff;    // Prescaler count
   logic             src_tick; // One tick of the chosen source
   logic             div_wrap; // Divider at its last state

   assign div_wrap = (div_ff == DIV_W'(DIV - 1));

   // Pick the tick of the selected source
   always_comb
   begin
      case (i_sel)
         tcc_pkg::tcc_clk_sys1:  src_tick = 1'b1;
         tcc_pkg::tcc_clk_sys16: src_tick = div_wrap;
         tcc_pkg::tcc_clk_pin:   src_tick = i_pin_rise;
         default:                src_tick = 1'b0;
      endcase
   end

   // Fixed divider runs only while the divided source is chosen
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         div_ff <= '0;
      else if (i_ce)
      begin
         if (!i_run || i_sel != tcc_pkg::tcc_clk_sys16)
            div_ff <= '0;
         else
            div_ff <= div_ff + DIV_W'(1);
      end
   end

   // Prescaler divides source ticks by i_ps plus one
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         ps_ff <= '0;
      else if (i_ce)
      begin
         if (!i_run)
            ps_ff <= '0;
         else if (src_tick)
            ps_ff <= (ps_ff == i_ps) ? '0 : ps_ff + PS_W'(1);
      end
   end

   // Counter increment request
   assign o_inc = i_run & src_tick & (ps_ff == i_ps);

endmodule

`default_nettype wire

// >>> src/tcc_core.sv
// Timer counter with compare, capture, event flags and requests
`timescale 1ns/1ps
`default_nettype none
`include "tcc_map.svh"

// Functional notes
// (RULE_01) Writing one clears capture flag
// (RULE_02) Edge field 01 captures rising, requests
// (RULE_03) Field 10 captures falling; 00 none
// (RULE_04) Compare reference against free-running counter
// (RULE_05) Match needs equality plus next increment
// (RULE_06) Programmed pin edge copies counter
// (RULE_07) Software avoids pin clock during capture
// (RULE_08) Counter readable anytime, counting undisturbed
// (RULE_09) Any counter write clears it
// (RULE_10) Count on sysclk/1, sysclk/16 or pin
// (RULE_11) Flags set regardless of request enables
// (RULE_12) DMA acknowledge clears both flags
// (RULE_13) Writing one clears reference flag
// (RULE_14) Reference flag requests interrupt or DMA
module tcc_core
#(
   parameter int PS_W = 8
)
(
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rstn,
   input  wire logic                   i_ce,
   input  wire logic [`TCC_ADDR_W-1:0] i_addr,
   input  wire logic [`TCC_DATA_W-1:0] i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic      [`TCC_DATA_W-1:0] o_rdata,
   input  wire logic                   i_timer_input_pin,
   input  wire logic                   i_dma_ack,
   output logic                        o_irq,
   output logic                        o_dma_req
);

   logic [`TCC_MODE_W-1:0]  timer_mode_control_ff;   // Mode control register
   logic [`TCC_XMODE_W-1:0] timer_extended_mode_ff;  // Extended mode register
   logic [`TCC_EVT_W-1:0]   timer_event_flags_ff;    // Sticky event flags
   logic [`TCC_EVT_W-1:0]   irq_mask_ff;             // Interrupt mask
   logic [`TCC_DATA_W-1:0]  timer_compare_value_ff;  // Reference value
   logic [`TCC_DATA_W-1:0]  timer_captured_value_ff; // Captured count
   logic [`TCC_DATA_W-1:0]  timer_count_value_ff;    // Free-running counter
   logic [`TCC_DATA_W-1:0]  rdata_ff;                // Read data
   logic                    irq_ff;                  // Interrupt output
   logic                    dma_req_ff;              // DMA request output

   logic                    run;         // Timer enabled
   logic                    frr;         // Restart on match
   logic                    compare_request_enable;
   logic                    dma_request_enable;
   logic                    mode16;      // Mirror increment
   tcc_pkg::tcc_clk_sel_type clk_sel;
   tcc_pkg::tcc_cap_edge_type cap_sel;
   logic [PS_W-1:0]         ps;          // Prescaler value
   logic                    pin_level;   // Synchronised pin
   logic                    pin_rise;    // Rising edge pulse
   logic                    pin_fall;    // Falling edge pulse
   logic                    inc;         // Counter increment
   logic                    ref_match;   // Reference event
   logic                    cap_edge;    // Capture event
   logic                    wr_mode;
   logic                    wr_xmode;
   logic                    wr_event;
   logic                    wr_cmp;
   logic                    wr_count;
   logic                    wr_mask;
   logic [`TCC_EVT_W-1:0]   evt_set;     // Hardware set terms
   logic [`TCC_EVT_W-1:0]   evt_clr;     // Software and DMA clear terms
   logic [`TCC_EVT_W-1:0]   req_en;      // Per flag request enables
   logic [`TCC_EVT_W-1:0]   req_act;     // Flags that raise a request
   logic [`TCC_DATA_W-1:0]  step;        // Counter step
   logic [`TCC_DATA_W-1:0]  nxt_rdata;

   // Field views of the mode registers
   assign run     = timer_mode_control_ff[`TCC_MODE_EN_BIT];
   assign frr     = timer_mode_control_ff[`TCC_MODE_FRR_BIT];
   assign compare_request_enable = timer_mode_control_ff[`TCC_MODE_COMPARE_REQUEST_ENABLE_BIT];
   assign clk_sel = tcc_pkg::tcc_clk_sel_type'(
                    timer_mode_control_ff[`TCC_MODE_CLK_MSB:`TCC_MODE_CLK_LSB]);
   assign cap_sel = tcc_pkg::tcc_cap_edge_type'(
                    timer_mode_control_ff[`TCC_MODE_CE_MSB:`TCC_MODE_CE_LSB]);
   assign ps      = timer_mode_control_ff[`TCC_MODE_PS_MSB:`TCC_MODE_PS_LSB];
   assign dma_request_enable = timer_extended_mode_ff[`TCC_XMODE_DMA_BIT];
   assign mode16  = timer_extended_mode_ff[`TCC_XMODE_M16_BIT];

   // Write decode
   assign wr_mode  = i_wr && (i_addr == `TCC_OFS_MODE);
   assign wr_xmode = i_wr && (i_addr == `TCC_OFS_XMODE);
   assign wr_event = i_wr && (i_addr == `TCC_OFS_EVENT);
   assign wr_cmp   = i_wr && (i_addr == `TCC_OFS_COMPARE);
   assign wr_count = i_wr && (i_addr == `TCC_OFS_COUNT);
   assign wr_mask  = i_wr && (i_addr == `TCC_OFS_IRQ_MASK);

   // Pin synchroniser and edge detect
   tcc_pin_edge u_pin_edge
   (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .i_ce      (i_ce),
      .i_pin     (i_timer_input_pin),
      .o_level   (pin_level),
      .o_rise    (pin_rise),
      .o_fall    (pin_fall)
   );

   // Source select and prescaler produce the increment tick
   tcc_prescaler #(.PS_W(PS_W)) u_prescaler // RULE_10
   (
      .i_clk_sys  (i_clk_sys),
      .i_rstn     (i_rstn),
      .i_ce       (i_ce),
      .i_run      (run),
      .i_sel      (clk_sel),
      .i_pin_rise (pin_rise),
      .i_ps       (ps),
      .o_inc      (inc)
   );

   // Match only when equal and the next increment is due
   assign ref_match = inc && (timer_count_value_ff == timer_compare_value_ff); // RULE_04 RULE_05

   // Capture on the programmed edge; off selects nothing
   always_comb
   begin
      case (cap_sel)
         tcc_pkg::tcc_cap_rise: cap_edge = pin_rise; // RULE_02
         tcc_pkg::tcc_cap_fall: cap_edge = pin_fall; // RULE_03
         tcc_pkg::tcc_cap_any:  cap_edge = pin_rise | pin_fall;
         default:               cap_edge = 1'b0; // RULE_03
      endcase
   end

   assign step = mode16 ? `TCC_STEP_M16 : `TCC_STEP_ONE;

   // Mode registers, unused bits kept at zero
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         timer_mode_control_ff  <= `TCC_RST_MODE;
         timer_extended_mode_ff <= `TCC_RST_XMODE;
      end
      else if (i_ce)
      begin
         if (wr_mode)
            timer_mode_control_ff <= i_wdata[`TCC_MODE_W-1:0] & `TCC_MODE_MASK;
         if (wr_xmode)
            timer_extended_mode_ff <= i_wdata[`TCC_XMODE_W-1:0] & `TCC_XMODE_MASK;
      end
   end

   // Compare value and interrupt mask
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         timer_compare_value_ff <= `TCC_RST_WORD;
         irq_mask_ff            <= `TCC_RST_EVT;
      end
      else if (i_ce)
      begin
         if (wr_cmp)
            timer_compare_value_ff <= i_wdata;
         if (wr_mask)
            irq_mask_ff <= i_wdata[`TCC_EVT_W-1:0];
      end
   end

   // Counter: write clears, stopped timer holds zero, match with frr restarts, else counts
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         timer_count_value_ff <= `TCC_RST_WORD;
      else if (i_ce)
      begin
         if (wr_count || !run)
            timer_count_value_ff <= `TCC_RST_WORD; // RULE_09
         else if (ref_match && frr)
            timer_count_value_ff <= `TCC_RST_WORD;
         else if (inc)
            timer_count_value_ff <= timer_count_value_ff + step; // RULE_10
      end
   end

   // Capture register takes the count on the chosen edge
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         timer_captured_value_ff <= `TCC_RST_WORD;
      else if (i_ce && cap_edge)
         timer_captured_value_ff <= timer_count_value_ff; // RULE_06
   end

   // Set and clear terms of the flags; set wins over clear
   assign evt_set[`TCC_EVT_CAP_BIT] = cap_edge; // RULE_11
   assign evt_set[`TCC_EVT_REF_BIT] = ref_match; // RULE_11
   assign evt_clr = (wr_event ? i_wdata[`TCC_EVT_W-1:0] : `TCC_RST_EVT) // RULE_01 RULE_13
                  | {`TCC_EVT_W{i_dma_ack & dma_req_ff}}; // RULE_12

   // Sticky event flags
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         timer_event_flags_ff <= `TCC_RST_EVT;
      else if (i_ce)
         timer_event_flags_ff <= (timer_event_flags_ff & ~evt_clr) | evt_set;
   end

   // Which flags may raise a request
   assign req_en[`TCC_EVT_CAP_BIT] = (cap_sel != tcc_pkg::tcc_cap_off);
   assign req_en[`TCC_EVT_REF_BIT] = compare_request_enable;
   assign req_act = timer_event_flags_ff & req_en;

   // Request routing: interrupt or DMA by the DMA enable
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         irq_ff     <= 1'b0;
         dma_req_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         irq_ff     <= ~dma_request_enable & (|(req_act & irq_mask_ff)); // RULE_02 RULE_14
         dma_req_ff <= dma_request_enable & (|req_act); // RULE_03 RULE_14
      end
   end

   // Read mux; unmapped reads return zero
   always_comb
   begin
      nxt_rdata = `TCC_RST_WORD;
      if (i_addr == `TCC_OFS_MODE)
         nxt_rdata[`TCC_MODE_W-1:0] = timer_mode_control_ff;
      else if (i_addr == `TCC_OFS_XMODE)
         nxt_rdata[`TCC_XMODE_W-1:0] = timer_extended_mode_ff;
      else if (i_addr == `TCC_OFS_EVENT)
         nxt_rdata[`TCC_EVT_W-1:0] = timer_event_flags_ff;
      else if (i_addr == `TCC_OFS_COMPARE)
         nxt_rdata = timer_compare_value_ff;
      else if (i_addr == `TCC_OFS_CAPTURE)
         nxt_rdata = timer_captured_value_ff;
      else if (i_addr == `TCC_OFS_COUNT)
         nxt_rdata = timer_count_value_ff; // RULE_08
      else if (i_addr == `TCC_OFS_IRQ_MASK)
         nxt_rdata[`TCC_EVT_W-1:0] = irq_mask_ff;
   end

   // Read data stands one cycle after the strobe only
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         rdata_ff <= `TCC_RST_WORD;
      else if (i_ce)
         rdata_ff <= i_rd ? nxt_rdata : `TCC_RST_WORD;
   end

   assign o_rdata   = rdata_ff;
   assign o_irq     = irq_ff;
   assign o_dma_req = dma_req_ff;

   // Writing one to the capture flag clears it
   property p_cap_w1c;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_ce && wr_event && i_wdata[`TCC_EVT_CAP_BIT] && !cap_edge)
      |=> !timer_event_flags_ff[`TCC_EVT_CAP_BIT];
   endproperty
   a_cap_w1c: assert property (p_cap_w1c) else $error("capture flag not cleared"); // RULE_01

   // Rising capture latches count and sets flag
   property p_rise_cap;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_ce && cap_sel == tcc_pkg::tcc_cap_rise && pin_rise)
      |=> timer_event_flags_ff[`TCC_EVT_CAP_BIT]
          && timer_captured_value_ff == $past(timer_count_value_ff);
   endproperty
   a_rise_cap: assert property (p_rise_cap) else $error("rising capture missed"); // RULE_02

   // Falling capture latches count and sets flag
   property p_fall_cap;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_ce && cap_sel == tcc_pkg::tcc_cap_fall && pin_fall)
      |=> timer_event_flags_ff[`TCC_EVT_CAP_BIT]
          && timer_captured_value_ff == $past(timer_count_value_ff);
   endproperty
   a_fall_cap: assert property (p_fall_cap) else $error("falling capture missed"); // RULE_03

   // Capture off leaves the capture register alone
   property p_cap_off;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (cap_sel == tcc_pkg::tcc_cap_off) |=> $stable(timer_captured_value_ff);
   endproperty
   a_cap_off: assert property (p_cap_off) else $error("capture while disabled"); // RULE_06

   // Equal count with increment due sets the reference flag
   property p_ref_match;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_ce && run && inc && timer_count_value_ff == timer_compare_value_ff)
      |=> timer_event_flags_ff[`TCC_EVT_REF_BIT];
   endproperty
   a_ref_match: assert property (p_ref_match) else $error("reference match missed"); // RULE_05

   // Counter reads return the current count
   property p_count_read;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_ce && i_rd && i_addr == `TCC_OFS_COUNT)
      |=> o_rdata == $past(timer_count_value_ff);
   endproperty
   a_count_read: assert property (p_count_read) else $error("count read wrong"); // RULE_08

   // Any write to the counter clears it
   property p_count_clr;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_ce && wr_count) |=> timer_count_value_ff == `TCC_RST_WORD;
   endproperty
   a_count_clr: assert property (p_count_clr) else $error("count not cleared"); // RULE_09

   // Undivided system clock with zero prescale counts every cycle
   property p_sys1_count;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_ce && run && clk_sel == tcc_pkg::tcc_clk_sys1 && ps == '0
       && !wr_count && !wr_mode && !(frr && ref_match))
      |=> timer_count_value_ff == $past(timer_count_value_ff) + $past(step);
   endproperty
   a_sys1_count: assert property (p_sys1_count) else $error("count did not advance"); // RULE_10

   // DMA acknowledge clears both flags
   property p_dma_ack;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_ce && i_dma_ack && dma_req_ff && !cap_edge && !ref_match)
      |=> timer_event_flags_ff == `TCC_RST_EVT;
   endproperty
   a_dma_ack: assert property (p_dma_ack) else $error("ack left flags set"); // RULE_12

   // Reference flag with request enable raises the right request
   property p_ref_req;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_ce && timer_event_flags_ff[`TCC_EVT_REF_BIT] && compare_request_enable)
      |=> (o_dma_req == $past(dma_request_enable))
          && ($past(dma_request_enable) || !$past(irq_mask_ff[`TCC_EVT_REF_BIT]) || o_irq);
   endproperty
   a_ref_req: assert property (p_ref_req) else $error("reference request wrong"); // RULE_14

endmodule

`default_nettype wire

// >>> verification/tcc_dma_model.sv
// DMA controller model that acknowledges timer requests
`timescale 1ns/1ps
`default_nettype none

module tcc_dma_model
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rstn,
   input  wire logic       i_slow,
   input  wire logic       i_dma_req,
   output logic            o_dma_ack,
   output logic [7:0]      o_acks
);
   logic [1:0] wait_ff; // Cycles spent on the pending request
   logic [1:0] hold_ff; // Ignore the request while it falls

   // Acknowledge after zero or three cycles, then back off
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         wait_ff   <= 2'h0;
         hold_ff   <= 2'h0;
         o_dma_ack <= 1'b0;
         o_acks    <= 8'h00;
      end
      else if (o_dma_ack)
      begin
         o_dma_ack <= 1'b0;
         hold_ff   <= 2'h2;
      end
      else if (hold_ff != 2'h0)
         hold_ff <= hold_ff - 2'h1;
      else if (i_dma_req && wait_ff == (i_slow ? 2'h3 : 2'h0))
      begin
         // Transfer done: one acknowledge pulse
         o_dma_ack <= 1'b1;
         o_acks    <= o_acks + 8'h01;
         wait_ff   <= 2'h0;
      end
      else if (i_dma_req)
         wait_ff <= wait_ff + 2'h1;
   end
endmodule

`default_nettype wire

// >>> verification/timer_capture_compare_core_bench.sv
// Self-checking bench for the timer capture and compare core
`timescale 1ns/1ps
`default_nettype none
`include "tcc_map.svh"

module timer_capture_compare_core_bench;
   typedef struct {string nm; logic [31:0] e; logic [31:0] m;} tcc_note_type;
   tcc_note_type q[$];              // Expected read results, oldest first
   logic         clk, rstn, wr, rd; // Clock, reset and strobes
   logic         pin, slow, ack;    // Timer pin, model speed, acknowledge
   logic         irq, dreq, rd_seen;
   logic         clk_en;            // Core clock enable, low freezes it
   logic [7:0]   addr, acks;
   logic [31:0]  wdata, rdata, rdat;
   logic [31:0]  rnd;               // Random compare value kept for its read back
   logic [1:0]   ce;                // Capture edge under test
   logic         s;                 // Level the capturing edge ends on
   int           errors, checks_done, seed, i, j;

   // Device under test
   tcc_core u_dut
   (
      .i_clk_sys(clk), .i_rstn(rstn), .i_ce(clk_en), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_timer_input_pin(pin), .i_dma_ack(ack), .o_irq(irq), .o_dma_req(dreq)
   );

   // DMA controller on the far side
   tcc_dma_model u_dma
   (
      .i_clk_sys(clk), .i_rstn(rstn), .i_slow(slow),
      .i_dma_req(dreq), .o_dma_ack(ack), .o_acks(acks)
   );

   // 20 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Compare one result and count it
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One bus cycle; a read notes its expected data
   task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input string nm);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      if (!w)
         q.push_back('{nm, d, m});
      @(posedge clk);
   endtask

   // Release the strobes for some cycles
   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   // Read a register into rdat for a window check
   task automatic poll(input logic [7:0] a);
      op(1'b0, a, 0, 0, "poll");
      idle(1);
      @(negedge clk);
      #1;
   endtask

   // Check both request outputs once settled
   task automatic pins(input logic ei, input logic ed);
      idle(2);
      @(negedge clk);
      chk("irq", ei, irq);
      chk("dma request", ed, dreq);
   endtask

   // Report and end the run
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Read data stand in the cycle after the strobe
   always @(posedge clk) rd_seen <= rd;
   always @(negedge clk)
   begin
      if (rd_seen)
      begin
         rdat = rdata;
         chk(q[0].nm, q[0].e, rdata & q[0].m);
         void'(q.pop_front());
      end
   end

   // Watchdog against a hang
   initial
   begin
      #1000000;
      errors++;
      finish_test;
   end

   // Main sequence
   initial
   begin
      seed = 36;
      rstn = 1'b0;
      {wr, rd, pin, slow, clk_en} = 5'h01;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      for (i = 0; i < 8; i++) op(1'b0, 8'(i * 4), 0, '1, "reset value");
      $display("test reset done");
      // Register access, read-only capture, masked ext mode
      rnd = $random(seed);
      op(1'b1, `TCC_OFS_COMPARE, rnd, 0, "");
      op(1'b1, `TCC_OFS_IRQ_MASK, 32'h0000_0003, 0, "");
      op(1'b1, `TCC_OFS_CAPTURE, 32'hFFFF_FFFF, 0, "");
      op(1'b1, `TCC_OFS_XMODE, 32'hFFFF_FFFF, 0, "");
      op(1'b0, `TCC_OFS_COMPARE, rnd, '1, "compare");
      op(1'b0, `TCC_OFS_CAPTURE, 0, '1, "capture");
      op(1'b0, `TCC_OFS_XMODE, 32'h0000_0081, '1, "ext mode");
      op(1'b1, `TCC_OFS_XMODE, 0, 0, "");
      $display("test registers done");
      // Any write clears the counter; back-to-back reads see it run
      op(1'b1, `TCC_OFS_MODE, 32'h0000_0003, 0, "");
      op(1'b1, `TCC_OFS_COUNT, $random(seed), 0, "");
      for (j = 0; j < 3; j++) op(1'b0, `TCC_OFS_COUNT, j, '1, "count");
      // Clock enable low for five edges freezes the cleared counter
      op(1'b1, `TCC_OFS_COUNT, 0, 0, "");
      clk_en <= 1'b0;
      idle(5);
      clk_en <= 1'b1;
      op(1'b0, `TCC_OFS_COUNT, 0, '1, "frozen count");
      $display("test count done");
      // Reference match after compare plus one intervals
      op(1'b1, `TCC_OFS_MODE, 0, 0, "");
      op(1'b1, `TCC_OFS_COMPARE, 32'h0000_0005, 0, "");
      op(1'b1, `TCC_OFS_EVENT, 32'h0000_0003, 0, "");
      op(1'b1, `TCC_OFS_MODE, 32'h0000_0003, 0, "");
      op(1'b1, `TCC_OFS_COUNT, 0, 0, "");
      for (j = 1; j < 8; j++) op(1'b0, `TCC_OFS_EVENT, (j == 7) ? 2 : 0, '1, "ref");
      pins(1'b0, 1'b0);
      op(1'b1, `TCC_OFS_MODE, 32'h0000_0013, 0, "");
      pins(1'b1, 1'b0);
      op(1'b1, `TCC_OFS_IRQ_MASK, 0, 0, "");
      pins(1'b0, 1'b0);
      op(1'b1, `TCC_OFS_IRQ_MASK, 32'h0000_0003, 0, "");
      op(1'b1, `TCC_OFS_EVENT, 32'h0000_0001, 0, "");
      op(1'b0, `TCC_OFS_EVENT, 32'h0000_0002, '1, "ref kept");
      pins(1'b1, 1'b0);
      op(1'b1, `TCC_OFS_EVENT, 32'h0000_0002, 0, "");
      op(1'b0, `TCC_OFS_EVENT, 0, '1, "ref cleared");
      pins(1'b0, 1'b0);
      op(1'b1, `TCC_OFS_COMPARE, 32'hFFFF_0000, 0, "");
      $display("test reference done");
      // Capture on each edge, by interrupt then by DMA, fast and slow
      for (i = 0; i < 4; i++)
      begin
         ce = 2'(i % 2 + 1);
         s = (ce == 2'h1);
         slow <= (i == 3);
         op(1'b1, `TCC_OFS_MODE, 32'h0000_0013, 0, "");
         pin <= s;
         op(1'b1, `TCC_OFS_XMODE, (i > 1) ? 32'h0000_0080 : 0, 0, "");
         idle(4);
         op(1'b1, `TCC_OFS_MODE, 32'({ce, 6'h03}), 0, "");
         op(1'b1, `TCC_OFS_EVENT, 32'h0000_0003, 0, "");
         pin <= !s;
         idle(8);
         op(1'b0, `TCC_OFS_EVENT, 0, '1, "other edge");
         pin <= s;
         op(1'b1, `TCC_OFS_COUNT, 0, 0, "");
         idle(8);
         poll(`TCC_OFS_CAPTURE);
         chk("capture window", 1, rdat >= 1 && rdat <= 4);
         chk("acks", (i > 1) ? i - 1 : 0, acks);
         pins(i < 2, 1'b0);
         op(1'b0, `TCC_OFS_EVENT, (i < 2) ? 1 : 0, '1, "cap flag");
         op(1'b1, `TCC_OFS_EVENT, 32'h0000_0001, 0, "");
         op(1'b0, `TCC_OFS_EVENT, 0, '1, "cap cleared");
         idle(1);
      end
      op(1'b1, `TCC_OFS_XMODE, 0, 0, "");
      op(1'b1, `TCC_OFS_MODE, 32'h0000_0003, 0, "");
      op(1'b1, `TCC_OFS_EVENT, 32'h0000_0003, 0, "");
      pin <= 1'b1;
      idle(6);
      pin <= 1'b0;
      idle(6);
      op(1'b0, `TCC_OFS_EVENT, 0, '1, "capture off");
      $display("test capture done");
      // Pin as clock only with capture off
      op(1'b1, `TCC_OFS_MODE, 32'h0000_0007, 0, "");
      op(1'b1, `TCC_OFS_COUNT, 0, 0, "");
      for (j = 0; j < 3; j++)
      begin
         pin <= 1'b1;
         idle(4);
         pin <= 1'b0;
         idle(4);
      end
      op(1'b0, `TCC_OFS_COUNT, 32'h0000_0003, '1, "pin count");
      // System clock divided by 16
      op(1'b1, `TCC_OFS_MODE, 32'h0000_0005, 0, "");
      op(1'b1, `TCC_OFS_COUNT, 0, 0, "");
      idle(48);
      poll(`TCC_OFS_COUNT);
      chk("div16 window", 1, rdat >= 3 && rdat <= 4);
      $display("test clock source done");
      finish_test;
   end
endmodule

`default_nettype wire
